/* File: cefb_flag_bank.sv */
// Charger event flag bank with serial register bus slave
`default_nettype none

module cefb_flag_bank #(
   parameter logic [6:0] DEV_ADDR = 7'h50
) (
   input  wire logic              i_mclk,
   input  wire logic              i_sys_rst,
   input  wire cefb_pkg::cefb_evt_t i_events,
   input  wire logic              i_scl,
   input  wire logic              i_sda,
   output logic                   o_sda_o,
   output logic                   o_sda_oe,
   output logic [23:0]            o_flags
);

   // Synchronised inputs
   cefb_pkg::cefb_evt_t evt_s;
   logic                scl_s;
   logic                sda_s;

   // Edge tracking
   logic [23:0]         lvl;
   logic [23:0]         lvl_q;
   logic [23:0]         rise;
   logic [23:0]         edge_any;
   logic [23:0]         set_ev;
   logic                one_shot;

   // Flag storage
   logic [23:0]         flags_q;
   logic [23:0]         flags_d;
   logic [23:0]         clr_ev;

   // Serial bus
   logic                scl_q;
   logic                sda_q;
   logic                scl_rise;
   logic                scl_fall;
   logic                start_det;
   logic                stop_det;
   cefb_pkg::cefb_state_t state_q;
   logic [2:0]          cnt_q;
   logic [7:0]          shift_q;
   logic [7:0]          byte_in;
   logic [7:0]          ptr_q;
   logic                ptr_set_q;
   logic                rw_q;
   logic [7:0]          tx_q;
   logic [7:0]          rd_data;
   logic [2:0]          rd_sel;
   logic                load_rd;
   logic                addr_hit;

   // One-hot select of a flag register by pointer
   function automatic logic [2:0] reg_sel(input logic [7:0] ptr);
      logic [2:0] sel;
      sel    = 3'h0;
      sel[2] = (ptr == cefb_pkg::TIMER_DETECT_OFFS);
      sel[1] = (ptr == cefb_pkg::THERM_OTG_OFFS);
      sel[0] = (ptr == cefb_pkg::PROT_FAULT_OFFS);
      return sel;
   endfunction

   cefb_sync #(
      .WIDTH   ($bits(cefb_pkg::cefb_evt_t)),
      .RST_LVL (1'b0)
   ) u_evt_sync (
      .i_mclk    (i_mclk),
      .i_sys_rst (i_sys_rst),
      .i_async   (i_events),
      .o_sync    (evt_s)
   );

   cefb_sync #(
      .WIDTH   (2),
      .RST_LVL (cefb_pkg::BUS_IDLE_LVL)
   ) u_bus_sync (
      .i_mclk    (i_mclk),
      .i_sys_rst (i_sys_rst),
      .i_async   ({i_scl, i_sda}),
      .o_sync    ({scl_s, sda_s})
   );

   // Detector levels placed at their flag positions; reserved slots stay zero
   assign lvl = {1'b0,
                 evt_s.port_detect_done,
                 evt_s.adc_conv_done,
                 evt_s.min_system_reg,
                 evt_s.fast_charge_expired,
                 evt_s.trickle_expired,
                 evt_s.precharge_expired,
                 evt_s.topoff_expired,
                 3'h0,
                 evt_s.battery_low_for_otg,
                 evt_s.thermistor_cold,
                 evt_s.thermistor_cool,
                 evt_s.thermistor_warm,
                 evt_s.thermistor_hot,
                 evt_s.battery_current_reg,
                 evt_s.input_bus_overvoltage,
                 evt_s.battery_overvoltage,
                 evt_s.input_overcurrent,
                 evt_s.battery_discharge_overcurrent,
                 evt_s.converter_overcurrent,
                 evt_s.second_input_overvoltage,
                 evt_s.first_input_overvoltage};

   assign one_shot = evt_s.adc_one_shot;
   assign rise     = lvl & ~lvl_q;
   assign edge_any = lvl ^ lvl_q;

   // Rising-edge flags
   // Both-edge flags
   // Conversion done counts only in one-shot mode
   assign set_ev = (rise & cefb_pkg::RISE_SET_MASK & ~cefb_pkg::ONE_SHOT_MASK)
                 | (edge_any & cefb_pkg::EDGE_SET_MASK)
                 | (rise & cefb_pkg::ONE_SHOT_MASK & {24{one_shot}});

   // Clear on read, but a new event in the same cycle wins
   assign clr_ev  = {{8{load_rd & rd_sel[2]}},
                     {8{load_rd & rd_sel[1]}},
                     {8{load_rd & rd_sel[0]}}};
   assign flags_d = (flags_q & ~clr_ev) | set_ev;

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         // All flags cleared at power-on
         flags_q <= {cefb_pkg::FLAG_RESET_VAL,
                     cefb_pkg::FLAG_RESET_VAL,
                     cefb_pkg::FLAG_RESET_VAL};
         lvl_q   <= 24'h00_00_00;
      end
      else
      begin
         flags_q <= flags_d;
         lvl_q   <= lvl;
      end
   end

   // Bus conditions
   assign scl_rise  = scl_s & ~scl_q;
   assign scl_fall  = ~scl_s & scl_q;
   assign start_det = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;
   assign byte_in   = {shift_q[6:0], sda_s};
   assign addr_hit  = (byte_in[7:1] == DEV_ADDR);

   // Read data; unmapped offsets and reserved bits read zero
   assign rd_sel  = reg_sel(ptr_q);
   assign rd_data = ({8{rd_sel[2]}} & flags_q[23:16])
                  | ({8{rd_sel[1]}} & flags_q[15:8])
                  | ({8{rd_sel[0]}} & flags_q[7:0]);

   // Byte loaded for transmit on this cycle
   assign load_rd = scl_fall
                  & ((state_q == cefb_pkg::ST_ADDR_ACK & o_sda_oe & rw_q)
                  | (state_q == cefb_pkg::ST_RD_ACK));

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         scl_q     <= cefb_pkg::BUS_IDLE_LVL;
         sda_q     <= cefb_pkg::BUS_IDLE_LVL;
         state_q   <= cefb_pkg::ST_IDLE;
         cnt_q     <= 3'h0;
         shift_q   <= 8'h00;
         ptr_q     <= 8'h00;
         ptr_set_q <= 1'b0;
         rw_q      <= 1'b0;
         tx_q      <= 8'h00;
         o_sda_oe  <= 1'b0;
         o_sda_o   <= 1'b0;
      end
      else
      begin
         scl_q   <= scl_s;
         sda_q   <= sda_s;
         o_sda_o <= 1'b0;
         if (start_det)
         begin
            state_q   <= cefb_pkg::ST_ADDR;
            cnt_q     <= 3'h0;
            ptr_set_q <= 1'b0;
            o_sda_oe  <= 1'b0;
         end
         else if (stop_det)
         begin
            state_q  <= cefb_pkg::ST_IDLE;
            o_sda_oe <= 1'b0;
         end
         else
         begin
            case (state_q)
               cefb_pkg::ST_IDLE:
               begin
                  o_sda_oe <= 1'b0;
               end
               cefb_pkg::ST_ADDR:
               begin
                  if (scl_rise)
                  begin
                     shift_q <= byte_in;
                     cnt_q   <= cnt_q + 3'h1;
                     if (cnt_q == 3'h7)
                     begin
                        rw_q    <= sda_s;
                        state_q <= addr_hit ? cefb_pkg::ST_ADDR_ACK : cefb_pkg::ST_IDLE;
                     end
                  end
               end
               cefb_pkg::ST_ADDR_ACK:
               begin
                  if (scl_fall)
                  begin
                     if (!o_sda_oe)
                     begin
                        o_sda_oe <= 1'b1;
                     end
                     else if (rw_q)
                     begin
                        tx_q     <= rd_data;
                        ptr_q    <= ptr_q + 8'h01;
                        o_sda_oe <= ~rd_data[7];
                        cnt_q    <= 3'h0;
                        state_q  <= cefb_pkg::ST_RD;
                     end
                     else
                     begin
                        o_sda_oe <= 1'b0;
                        cnt_q    <= 3'h0;
                        state_q  <= cefb_pkg::ST_WR;
                     end
                  end
               end
               cefb_pkg::ST_WR:
               begin
                  if (scl_rise)
                  begin
                     shift_q <= byte_in;
                     cnt_q   <= cnt_q + 3'h1;
                     if (cnt_q == 3'h7)
                     begin
                        // First byte sets the pointer; data writes are ignored
                        if (!ptr_set_q)
                        begin
                           ptr_q     <= byte_in;
                           ptr_set_q <= 1'b1;
                        end
                        state_q <= cefb_pkg::ST_WR_ACK;
                     end
                  end
               end
               cefb_pkg::ST_WR_ACK:
               begin
                  if (scl_fall)
                  begin
                     if (!o_sda_oe)
                     begin
                        o_sda_oe <= 1'b1;
                     end
                     else
                     begin
                        o_sda_oe <= 1'b0;
                        cnt_q    <= 3'h0;
                        state_q  <= cefb_pkg::ST_WR;
                     end
                  end
               end
               cefb_pkg::ST_RD:
               begin
                  if (scl_fall)
                  begin
                     cnt_q <= cnt_q + 3'h1;
                     if (cnt_q == 3'h7)
                     begin
                        o_sda_oe <= 1'b0;
                        state_q  <= cefb_pkg::ST_RD_ACK;
                     end
                     else
                     begin
                        tx_q     <= {tx_q[6:0], 1'b0};
                        o_sda_oe <= ~tx_q[6];
                     end
                  end
               end
               cefb_pkg::ST_RD_ACK:
               begin
                  if (scl_rise && sda_s)
                  begin
                     state_q <= cefb_pkg::ST_IDLE;
                  end
                  else if (scl_fall)
                  begin
                     tx_q     <= rd_data;
                     ptr_q    <= ptr_q + 8'h01;
                     o_sda_oe <= ~rd_data[7];
                     cnt_q    <= 3'h0;
                     state_q  <= cefb_pkg::ST_RD;
                  end
               end
               default:
               begin
                  state_q  <= cefb_pkg::ST_IDLE;
                  o_sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   assign o_flags = flags_q;

endmodule

`default_nettype wire

/* File: cefb_flag_bank_checker.sv */
// Port assertions for the charger event flag bank
`default_nettype none

module cefb_flag_bank_checker (
   input wire logic                i_mclk,
   input wire logic                i_sys_rst,
   input wire cefb_pkg::cefb_evt_t i_events,
   input wire logic                i_scl,
   input wire logic                i_sda,
   input wire logic                o_sda_o,
   input wire logic                o_sda_oe,
   input wire logic [23:0]         o_flags
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge i_mclk);
   endclocking

   rst_zero_a: assert property (i_sys_rst |=> o_flags == 24'h000000 && !o_sda_oe)
      else $error("not cleared by reset");
   reserved_zero_a: assert property (disable iff (i_sys_rst)
      o_flags[23] == 1'b0 && o_flags[15:13] == 3'h0)
      else $error("reserved bit set");
   ack_drive_a: assert property (disable iff (i_sys_rst)
      $rose(o_sda_oe) |-> !i_scl && !i_sda && !o_sda_o)
      else $error("data pin not pulled low while clock low");
   port_done_a: assert property (disable iff (i_sys_rst)
      $rose(i_events.port_detect_done) |-> ##[3:8] o_flags[22])
      else $error("port detect flag missing");
   adc_done_a: assert property (disable iff (i_sys_rst)
      $rose(i_events.adc_conv_done) && i_events.adc_one_shot |-> ##[3:8] o_flags[21])
      else $error("conversion flag missing");
   sys_reg_a: assert property (disable iff (i_sys_rst)
      $fell(i_events.min_system_reg) |-> ##[3:8] o_flags[20])
      else $error("min system flag missing");
   fast_tmo_a: assert property (disable iff (i_sys_rst)
      $rose(i_events.fast_charge_expired) |-> ##[3:8] o_flags[19])
      else $error("fast timer flag missing");
   cold_cross_a: assert property (disable iff (i_sys_rst)
      $changed(i_events.thermistor_cold) |-> ##[3:8] o_flags[11])
      else $error("cold flag missing");
   bat_reg_a: assert property (disable iff (i_sys_rst)
      $fell(i_events.battery_current_reg) |-> ##[3:8] o_flags[7])
      else $error("current reg flag missing");
   bus_ovp_a: assert property (disable iff (i_sys_rst)
      $rose(i_events.input_bus_overvoltage) |-> ##[3:8] o_flags[6])
      else $error("bus overvoltage flag missing");

endmodule

bind cefb_flag_bank cefb_flag_bank_checker chk_u (
   .i_mclk   (i_mclk),
   .i_sys_rst(i_sys_rst),
   .i_events (i_events),
   .i_scl    (i_scl),
   .i_sda    (i_sda),
   .o_sda_o  (o_sda_o),
   .o_sda_oe (o_sda_oe),
   .o_flags  (o_flags)
);

`default_nettype wire

/* File: cefb_host_model.sv */
// Serial bus host model that reads and writes the flag bank
`default_nettype none

module cefb_host_model #(
   parameter int unsigned HALF     = 12,
   parameter logic [6:0]  DEV_ADDR = 7'h50
) (
   input  wire logic i_mclk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_low
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end

   task automatic hw();
      repeat (HALF) @(negedge i_mclk);
   endtask

   // Start, also repeated start from clock low
   task automatic start_c();
      o_sda_low = 1'b0;
      hw();
      o_scl = 1'b1;
      hw();
      o_sda_low = 1'b1;
      hw();
      o_scl = 1'b0;
      hw();
   endtask

   task automatic stop_c();
      o_sda_low = 1'b1;
      hw();
      o_scl = 1'b1;
      hw();
      o_sda_low = 1'b0;
      hw();
   endtask

   // Data held past clock fall so slave never sees a false start
   task automatic bit_c(input logic b, output logic r);
      o_sda_low = ~b;
      hw();
      o_scl = 1'b1;
      hw();
      r = i_sda;
      o_scl = 1'b0;
      repeat (4) @(negedge i_mclk);
   endtask

   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
         bit_c(tx[i], rx[i]);
   endtask

   // Read from the pointer left by the last access, last byte refused
   task automatic rd_cur(input int n, output logic [23:0] d, output logic nak);
      logic [7:0] b;
      logic       x;
      d = 24'h000000;
      start_c();
      xfer({DEV_ADDR, 1'b1}, b);
      bit_c(1'b1, nak);
      for (int k = 0; k < n; k++)
      begin
         xfer(8'hFF, b);
         d = {d[15:0], b};
         bit_c(k == n - 1, x);
      end
      stop_c();
   endtask

   // Pointer, repeated start, n bytes, last one refused
   task automatic rd(input logic [7:0] ptr, input int n, output logic [23:0] d,
                     output logic [2:0] nak);
      logic [7:0] b;
      start_c();
      xfer({DEV_ADDR, 1'b0}, b);
      bit_c(1'b1, nak[2]);
      xfer(ptr, b);
      bit_c(1'b1, nak[1]);
      rd_cur(n, d, nak[0]);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] ptr, dat, output logic [2:0] nak);
      logic [7:0] b;
      start_c();
      xfer({a, 1'b0}, b);
      bit_c(1'b1, nak[2]);
      xfer(ptr, b);
      bit_c(1'b1, nak[1]);
      xfer(dat, b);
      bit_c(1'b1, nak[0]);
      stop_c();
   endtask

endmodule

`default_nettype wire

/* File: cefb_pkg.sv */
// Constants and types shared by the charger event flag bank
`default_nettype none

package cefb_pkg;

   // Register offsets on the serial register bus and flag register reset value
   localparam logic [7:0] TIMER_DETECT_OFFS  = 8'h24;
   localparam logic [7:0] THERM_OTG_OFFS     = 8'h25;
   localparam logic [7:0] PROT_FAULT_OFFS    = 8'h26;
   localparam logic [7:0] FLAG_RESET_VAL     = 8'h00;

   // Number of flag registers and flat flag vector width
   localparam int unsigned NUM_FLAG_REGS     = 3;
   localparam int unsigned FLAG_VEC_W        = 24;

   // Timer/detection register fields
   localparam int unsigned PORT_DETECT_BIT   = 6;
   localparam int unsigned ADC_DONE_BIT      = 5;
   localparam int unsigned MIN_SYS_REG_BIT   = 4;
   localparam int unsigned FAST_TMO_BIT      = 3;
   localparam int unsigned TRICKLE_TMO_BIT   = 2;
   localparam int unsigned PRECHG_TMO_BIT    = 1;
   localparam int unsigned TOPOFF_TMO_BIT    = 0;

   // Thermistor/OTG register fields
   localparam int unsigned BAT_LOW_OTG_BIT   = 4;
   localparam int unsigned THERM_COLD_BIT    = 3;
   localparam int unsigned THERM_COOL_BIT    = 2;
   localparam int unsigned THERM_WARM_BIT    = 1;
   localparam int unsigned THERM_HOT_BIT     = 0;

   // Protection register fields
   localparam int unsigned BAT_CUR_REG_BIT   = 7;
   localparam int unsigned BUS_OVP_BIT       = 6;
   localparam int unsigned BAT_OVP_BIT       = 5;
   localparam int unsigned IN_OCP_BIT        = 4;
   localparam int unsigned BAT_OCP_BIT       = 3;
   localparam int unsigned CONV_OCP_BIT      = 2;
   localparam int unsigned IN2_OVP_BIT       = 1;
   localparam int unsigned IN1_OVP_BIT       = 0;

   // Flat vector: timer/detect [23:16], thermistor/OTG [15:8], protection [7:0]
   localparam logic [23:0] RISE_SET_MASK     = 24'h6F_10_7F;
   localparam logic [23:0] EDGE_SET_MASK     = 24'h10_0F_80;
   localparam logic [23:0] ONE_SHOT_MASK     = 24'h20_00_00;

   // Serial bus idle level and byte size
   localparam logic        BUS_IDLE_LVL      = 1'b1;
   localparam int unsigned BYTE_BITS         = 8;

   // Levels from the analog detectors
   typedef struct packed {
      logic port_detect_done;
      logic adc_conv_done;
      logic adc_one_shot;
      logic min_system_reg;
      logic fast_charge_expired;
      logic trickle_expired;
      logic precharge_expired;
      logic topoff_expired;
      logic battery_low_for_otg;
      logic thermistor_cold;
      logic thermistor_cool;
      logic thermistor_warm;
      logic thermistor_hot;
      logic battery_current_reg;
      logic input_bus_overvoltage;
      logic battery_overvoltage;
      logic input_overcurrent;
      logic battery_discharge_overcurrent;
      logic converter_overcurrent;
      logic second_input_overvoltage;
      logic first_input_overvoltage;
   } cefb_evt_t;

   // Serial bus state
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WR,
      ST_WR_ACK,
      ST_RD,
      ST_RD_ACK
   } cefb_state_t;

endpackage

`default_nettype wire

/* File: cefb_sync.sv */
// Three-stage input synchroniser with agreement filter
`default_nettype none

module cefb_sync #(
   parameter int unsigned WIDTH   = 1,
   parameter logic        RST_LVL = 1'b0
) (
   input  wire logic             i_mclk,
   input  wire logic             i_sys_rst,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] out_d;

   // Accept a bit only when stages two and three agree
   assign out_d = (s2_q & s3_q) | (o_sync & (s2_q ^ s3_q));

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         s1_q   <= {WIDTH{RST_LVL}};
         s2_q   <= {WIDTH{RST_LVL}};
         s3_q   <= {WIDTH{RST_LVL}};
         o_sync <= {WIDTH{RST_LVL}};
      end
      else
      begin
         s1_q   <= i_async;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         o_sync <= out_d;
      end
   end

endmodule

`default_nettype wire

/* File: test_charger_event_flag_bank.sv */
// Self-checking bench for the charger event flag bank
`default_nettype none

module test_charger_event_flag_bank;
   timeunit 1ns;
   timeprecision 1ps;

   // Detector bit and the flag bit it sets
   localparam int EV[19] = '{20, 17, 16, 15, 14, 13, 12, 11, 10, 9, 8, 7, 6, 5, 4, 3, 2, 1, 0};
   localparam int FL[19] = '{22, 20, 19, 18, 17, 16, 12, 11, 10, 9, 8, 7, 6, 5, 4, 3, 2, 1, 0};
   localparam logic [23:0] BOTH = 24'h10_0F_80;

   logic                i_mclk = 1'b0;
   logic                i_sys_rst = 1'b1;
   cefb_pkg::cefb_evt_t ev = '0;
   logic                scl;
   logic                sda_low;
   logic                sda_oe;
   logic                sda_o;
   logic [23:0]         flags;
   wire                 sda;
   int                  n_mismatch = 0;
   int                  cmp_count = 0;

   always #12.5 i_mclk = ~i_mclk;
   assign sda = ~((sda_oe & ~sda_o) | sda_low);

   cefb_flag_bank dut_u (
      .i_mclk   (i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_events (ev),
      .i_scl    (scl),
      .i_sda    (sda),
      .o_sda_o  (sda_o),
      .o_sda_oe (sda_oe),
      .o_flags  (flags)
   );

   cefb_host_model host_u (
      .i_mclk   (i_mclk),
      .i_sda    (sda),
      .o_scl    (scl),
      .o_sda_low(sda_low)
   );

   task automatic give_verdict();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [23:0] got, exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic clk(input int n);
      repeat (n) @(negedge i_mclk);
   endtask

   task automatic rd_b(input logic [7:0] ptr, input int n, output logic [23:0] d);
      logic [2:0] nak;
      host_u.rd(ptr, n, d, nak);
      chk({21'h0, nak}, 24'h0, "read ack");
   endtask

   // Zero after reset, also after a reset in mid-run
   task automatic t_reset();
      logic [23:0] d;
      chk(flags, 24'h0, "reset flags");
      rd_b(8'h24, 3, d);
      chk(d, 24'h0, "reset read");
      ev.topoff_expired = 1'b1;
      clk(10);
      chk(flags, 24'h01_00_00, "before reset");
      i_sys_rst = 1'b1;
      clk(6);
      ev.topoff_expired = 1'b0;
      i_sys_rst = 1'b0;
      clk(8);
      chk(flags, 24'h0, "second reset");
   endtask

   // Each detector except conversion done sets its own flag, held until read
   task automatic t_edges();
      logic [23:0] d;
      logic [23:0] m;
      logic [7:0]  p;
      for (int k = 0; k < 19; k++)
      begin
         m = 24'h1 << FL[k];
         p = 8'h26 - 8'(FL[k] / 8);
         ev[EV[k]] = 1'b1;
         clk(10);
         chk(flags, m, "rise");
         rd_b(p, 1, d);
         chk(d, 24'h1 << (FL[k] % 8), "read");
         chk(flags, 24'h0, "clear on read");
         ev[EV[k]] = 1'b0;
         clk(10);
         chk(flags, m & BOTH, "fall");
         rd_b(p, 1, d);
      end
   endtask

   // Conversion done counts only in one-shot mode
   task automatic t_adc();
      logic [23:0] d;
      ev.adc_conv_done = 1'b1;
      clk(10);
      chk(flags, 24'h0, "adc continuous");
      ev.adc_conv_done = 1'b0;
      ev.adc_one_shot = 1'b1;
      clk(10);
      ev.adc_conv_done = 1'b1;
      clk(10);
      rd_b(8'h24, 1, d);
      chk(d, 24'h20, "adc one-shot");
      ev = '0;
      clk(10);
   endtask

   // Writes ignored, foreign address refused, burst and unmapped reads
   task automatic t_bus();
      logic [23:0] d;
      logic [2:0]  nak;
      ev.thermistor_hot = 1'b1;
      ev.first_input_overvoltage = 1'b1;
      ev.topoff_expired = 1'b1;
      clk(10);
      host_u.wr(7'h50, 8'h25, 8'hE1, nak);
      chk({21'h0, nak}, 24'h0, "write ack");
      host_u.wr(7'h51, 8'h26, 8'h00, nak);
      chk({21'h0, nak}, 24'h7, "foreign address");
      chk(flags, 24'h01_01_01, "write ignored");
      rd_b(8'h24, 3, d);
      chk(d, 24'h01_01_01, "burst read");
      rd_b(8'h27, 1, d);
      chk(d, 24'h0, "unmapped");
      ev.battery_low_for_otg = 1'b1;
      ev.converter_overcurrent = 1'b1;
      clk(10);
      rd_b(8'h25, 1, d);
      chk(d, 24'h10, "pointer read");
      host_u.rd_cur(1, d, nak[0]);
      chk(d, 24'h04, "last pointer read");
      chk({23'h0, nak[0]}, 24'h0, "current read ack");
      ev = '0;
      clk(10);
   endtask

   initial
   begin
      clk(6);
      i_sys_rst = 1'b0;
      clk(8);
      t_reset();
      t_edges();
      t_adc();
      t_bus();
      give_verdict();
   end

   initial
   begin
      repeat (90000) @(posedge i_mclk);
      n_mismatch++;
      give_verdict();
   end

endmodule

`default_nettype wire
